// ==== csb_pkg.sv ====
package csb_pkg;

   localparam int PARITY_CHECK_OUTPUT_DELAY = 2;
   localparam logic [1:0] PB_SEL_RESET = 2'h0;
   localparam logic [1:0] STRAP_SETTLE = 2'h2;

   typedef enum logic [1:0]
   {
      CSB_RUN = 2'h0,
      CSB_SMM = 2'h1,
      CSB_STOP = 2'h3,
      CSB_PROBE = 2'h2
   } csb_mode_e;

   typedef struct packed
   {
      logic [31:0] addr;
      logic [7:0] ctrl;
   } csb_cycle_s;

   typedef struct packed
   {
      csb_cycle_s cyc;
      logic valid;
   } csb_mca_s;

   typedef struct packed
   {
      logic [1:0] pen_sync;
      logic [1:0] smi_sync;
      logic [1:0] stp_sync;
      logic [1:0] rs_sync;
      logic [1:0] flush_sync;
      logic [1:0] init_sync;
      logic smi_latched;
      csb_mode_e mode;
      csb_mca_s mca;
      logic mc_exception;
      logic [1:0] pb_sel;
      logic [PARITY_CHECK_OUTPUT_DELAY-1:0] perr_pipe;
      logic [PARITY_CHECK_OUTPUT_DELAY-1:0] burst_ready_in_pipe;
      logic parity_check_output_n;
      logic lock_active;
      logic split;
      logic page_write_through;
      logic stop_grant;
      logic cache_inval;
      logic [1:0] settle;
      logic reset_done;
      logic tristate_test;
      logic run_bist;
   } csb_state_s;

endpackage

// ==== csb_sideband.sv ====
`timescale 1ns/10ps
// Summary of operation
// - With parity checking enabled, a read parity error captures the cycle's address and control.
// - If machine check is also enabled, a machine check exception is raised before the next instruction.
// - Two select bits choose breakpoint or performance-monitor function for each shared pin.
// - After reset both shared pins act as performance-monitor outputs.
// - Probe ready asserts once execution halts for run/stop or probe mode.
// - Reset starts from a known state and invalidates caches without write-back.
// - Flush and init are sampled as reset releases to choose three-state test or self test.
// - Split cycle asserts during misaligned locked transfers.
// - A system management request is latched and enters management mode at an instruction boundary.
// - Management active stays asserted for the whole time in management mode.
// - A stop clock request halts at the next boundary and issues a stop grant, unless preempted.
// - Snoops are still serviced while stop clock is asserted.
// - Page write-through follows the write-through bit that applies to the cycle.
// - Parity check output goes low for one clock, three clocks after each erroring ready clock.
// - Bus lock asserts in the first locked cycle and drops after ready of the last one.
module csb_sideband
(
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic PARITY_ERROR_CHECK_ENABLE_B,
   input wire logic READ_PARITY_ERR,
   input wire logic BURST_READY_IN_B,
   input wire csb_pkg::csb_cycle_s CUR_CYCLE,
   input wire logic MACHINE_CHECK_ENABLE_BIT,
   input wire logic MCA_CLEAR,
   input wire logic PB_SEL_WR,
   input wire logic [1:0] PB_SEL_WDATA,
   input wire logic [1:0] BP_MATCH,
   input wire logic [1:0] PERFMON_EVENT,
   input wire logic RUN_STOP_REQ_B,
   input wire logic PROBE_ENTER,
   input wire logic PROBE_EXIT,
   input wire logic INSN_BOUNDARY,
   input wire logic HIGHER_PRI_INT,
   input wire logic RSM_EXEC,
   input wire logic SYS_MGMT_INTERRUPT_REQ_B,
   input wire logic STOP_CLOCK_REQUEST_B,
   input wire logic FLUSH_REQ_B,
   input wire logic INIT_REQ,
   input wire logic LOCK_START,
   input wire logic LOCK_LAST,
   input wire logic LOCK_MISALIGNED,
   input wire logic PWT_BIT,
   input wire logic SNOOP_REQ,
   output logic [1:0] PERFMON_BREAKPOINT_PINS,
   output logic [1:0] PIN_FUNCTION_SELECT,
   output logic PROBE_READY,
   output logic SYS_MGMT_ACTIVE_B,
   output logic STOP_GRANT_CYCLE,
   output logic EXEC_HALTED,
   output logic PARITY_CHECK_OUTPUT_B,
   output logic LOCK_B,
   output logic SPLIT_CYCLE,
   output logic PAGE_WRITE_THROUGH,
   output logic MACHINE_CHECK_EXC,
   output csb_pkg::csb_mca_s MCA_REGS,
   output logic CACHE_INVALIDATE,
   output logic TRISTATE_TEST,
   output logic RUN_BIST,
   output logic SNOOP_ACK
);
   import csb_pkg::*;

   csb_state_s s_q;
   csb_state_s s_d;
   logic pen_act;
   logic burst_ready_in_act;
   logic at_boundary;

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      s_d = s_q;
      s_d.pen_sync = {s_q.pen_sync[0], ~PARITY_ERROR_CHECK_ENABLE_B};
      s_d.smi_sync = {s_q.smi_sync[0], ~SYS_MGMT_INTERRUPT_REQ_B};
      s_d.stp_sync = {s_q.stp_sync[0], ~STOP_CLOCK_REQUEST_B};
      s_d.rs_sync = {s_q.rs_sync[0], ~RUN_STOP_REQ_B};
      s_d.flush_sync = {s_q.flush_sync[0], ~FLUSH_REQ_B};
      s_d.init_sync = {s_q.init_sync[0], INIT_REQ};
      s_d.stop_grant = 1'b0;
      s_d.cache_inval = 1'b0;
      // Caches invalidated on the first edge after reset release
      if (s_q.settle != STRAP_SETTLE)
         s_d.settle = s_q.settle + 2'h1;
      if (s_q.settle == 2'h0)
         s_d.cache_inval = 1'b1;
      // Straps taken once synchronisers show the level held across release
      if (s_q.settle == STRAP_SETTLE && !s_q.reset_done)
      begin
         s_d.reset_done = 1'b1;
         s_d.tristate_test = s_q.flush_sync[1] & ~s_q.init_sync[1];
         s_d.run_bist = s_q.init_sync[1] & ~s_q.flush_sync[1];
      end
      // Pending exception taken at the next boundary
      if (s_q.mc_exception && INSN_BOUNDARY)
         s_d.mc_exception = 1'b0;
      // Parity capture, held until software clears
      if (pen_act && READ_PARITY_ERR && burst_ready_in_act && !s_q.mca.valid)
      begin
         s_d.mca.cyc = CUR_CYCLE;
         s_d.mca.valid = 1'b1;
         if (MACHINE_CHECK_ENABLE_BIT)
            s_d.mc_exception = 1'b1;
      end
      else if (MCA_CLEAR)
         s_d.mca.valid = 1'b0;
      if (PB_SEL_WR)
         s_d.pb_sel = PB_SEL_WDATA;
      s_d.perr_pipe = {s_q.perr_pipe[PARITY_CHECK_OUTPUT_DELAY-2:0], READ_PARITY_ERR & burst_ready_in_act};
      s_d.parity_check_output_n = ~s_q.perr_pipe[PARITY_CHECK_OUTPUT_DELAY-1];
      if (LOCK_START)
         s_d.lock_active = 1'b1;
      else if (LOCK_LAST && burst_ready_in_act)
         s_d.lock_active = 1'b0;
      s_d.split = (LOCK_START | s_q.lock_active) & LOCK_MISALIGNED;
      s_d.page_write_through = PWT_BIT;
      unique case (s_q.mode)
         CSB_RUN:
         begin
            if (PROBE_ENTER || s_q.rs_sync[1])
               s_d.mode = CSB_PROBE;
            else if (at_boundary && s_q.smi_latched)
            begin
               s_d.mode = CSB_SMM;
               s_d.smi_latched = 1'b0;
            end
            else if (at_boundary && s_q.stp_sync[1] && !HIGHER_PRI_INT)
            begin
               s_d.mode = CSB_STOP;
               s_d.stop_grant = 1'b1;
            end
         end
         CSB_SMM:
            if (RSM_EXEC)
               s_d.mode = CSB_RUN;
         CSB_STOP:
            if (!s_q.stp_sync[1])
               s_d.mode = CSB_RUN;
         CSB_PROBE:
            if (PROBE_EXIT && !s_q.rs_sync[1])
               s_d.mode = CSB_RUN;
      endcase
      // New request wins over the clear on management entry
      if (s_q.smi_sync[1])
         s_d.smi_latched = 1'b1;
   end

   always_comb
   begin
      pen_act = s_q.pen_sync[1];
      burst_ready_in_act = ~BURST_READY_IN_B;
      at_boundary = INSN_BOUNDARY & ~s_q.mc_exception;
   end

   always_ff @(posedge SYS_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         s_q <= '0;
         s_q.mode <= CSB_RUN;
         s_q.pb_sel <= PB_SEL_RESET;
         s_q.parity_check_output_n <= 1'b1;
      end
      else
         s_q <= s_d;
   end

   // ****************************************
   // Outputs
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_pin
         // Select 1 means breakpoint, 0 means perfmon
         assign PERFMON_BREAKPOINT_PINS[gi] = s_q.pb_sel[gi] ? BP_MATCH[gi]
                                                              : PERFMON_EVENT[gi];
      end
   endgenerate

   assign PIN_FUNCTION_SELECT = s_q.pb_sel;
   assign PROBE_READY = (s_q.mode == CSB_PROBE);
   assign SYS_MGMT_ACTIVE_B = ~(s_q.mode == CSB_SMM);
   assign STOP_GRANT_CYCLE = s_q.stop_grant;
   assign EXEC_HALTED = (s_q.mode == CSB_STOP) | (s_q.mode == CSB_PROBE);
   assign PARITY_CHECK_OUTPUT_B = s_q.parity_check_output_n;
   assign LOCK_B = ~s_q.lock_active;
   assign SPLIT_CYCLE = s_q.split;
   assign PAGE_WRITE_THROUGH = s_q.page_write_through;
   assign MACHINE_CHECK_EXC = s_q.mc_exception;
   assign MCA_REGS = s_q.mca;
   assign CACHE_INVALIDATE = s_q.cache_inval;
   assign TRISTATE_TEST = s_q.tristate_test;
   assign RUN_BIST = s_q.run_bist;
   assign SNOOP_ACK = SNOOP_REQ;

   // ****************************************
   // Assertions
   // ****************************************
   sequence s_perr;
      READ_PARITY_ERR && burst_ready_in_act;
   endsequence

   property p_parity_check_output;
      @(posedge SYS_CLK) disable iff (!RST_B) s_perr |-> ##3 !PARITY_CHECK_OUTPUT_B;
   endproperty
   a_parity_check_output: assert property (p_parity_check_output) else $error("parity check not reported");

   property p_capture;
      @(posedge SYS_CLK) disable iff (!RST_B)
         (s_perr and (pen_act && !MCA_REGS.valid))
            |=> MCA_REGS.valid && MCA_REGS.cyc == $past(CUR_CYCLE);
   endproperty
   a_capture: assert property (p_capture) else $error("parity cycle not captured");

   property p_mce;
      @(posedge SYS_CLK) disable iff (!RST_B)
         (s_perr and (pen_act && !MCA_REGS.valid && MACHINE_CHECK_ENABLE_BIT))
            |=> MACHINE_CHECK_EXC;
   endproperty
   a_mce: assert property (p_mce) else $error("machine check not raised");

   property p_pb_reset;
      @(posedge SYS_CLK) disable iff (!RST_B)
         $rose(s_q.reset_done) |-> PIN_FUNCTION_SELECT == PB_SEL_RESET;
   endproperty
   a_pb_reset: assert property (p_pb_reset) else $error("pins not perfmon after reset");

   property p_pin_mux;
      @(posedge SYS_CLK) disable iff (!RST_B)
         !PIN_FUNCTION_SELECT[0] |-> PERFMON_BREAKPOINT_PINS[0] == PERFMON_EVENT[0];
   endproperty
   a_pin_mux: assert property (p_pin_mux) else $error("pin 0 mux wrong");

   property p_smm;
      @(posedge SYS_CLK) disable iff (!RST_B)
         (s_q.mode == CSB_RUN && s_q.smi_latched && at_boundary && !PROBE_ENTER
          && !s_q.rs_sync[1]) |=> !SYS_MGMT_ACTIVE_B;
   endproperty
   a_smm: assert property (p_smm) else $error("smm not entered");

   property p_smm_hold;
      @(posedge SYS_CLK) disable iff (!RST_B)
         (!SYS_MGMT_ACTIVE_B && !RSM_EXEC) |=> !SYS_MGMT_ACTIVE_B;
   endproperty
   a_smm_hold: assert property (p_smm_hold) else $error("smm active dropped");

   property p_stop_hold;
      @(posedge SYS_CLK) disable iff (!RST_B)
         (s_q.mode == CSB_STOP && s_q.stp_sync[1]) |=> EXEC_HALTED;
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("left stop grant early");

   property p_stop_grant;
      @(posedge SYS_CLK) disable iff (!RST_B)
         STOP_GRANT_CYCLE |-> s_q.mode == CSB_STOP && !$past(HIGHER_PRI_INT);
   endproperty
   a_stop_grant: assert property (p_stop_grant) else $error("bad stop grant");

   property p_lock;
      @(posedge SYS_CLK) disable iff (!RST_B) LOCK_START |=> !LOCK_B;
   endproperty
   a_lock: assert property (p_lock) else $error("lock not asserted");
endmodule

// ==== csb_chipset.sv ====
`timescale 1ns/10ps
module csb_chipset
(
   input wire logic STOP_ON,
   input wire logic SMI_ON,
   input wire logic [1:0] STRAP,
   output logic STOP_CLOCK_REQUEST_B,
   output logic SYS_MGMT_INTERRUPT_REQ_B,
   output logic FLUSH_REQ_B,
   output logic INIT_REQ
);
   // ********
   // Chipset side levels
   // ********
   assign STOP_CLOCK_REQUEST_B = ~STOP_ON;
   assign SYS_MGMT_INTERRUPT_REQ_B = ~SMI_ON;
   // Straps stay put across reset release
   assign FLUSH_REQ_B = ~STRAP[0];
   assign INIT_REQ = STRAP[1];
endmodule

// ==== csb_sideband_test.sv ====
`timescale 1ns/10ps
module csb_sideband_test;
   import csb_pkg::*;
   typedef struct packed {logic [1:0] sel, bp, pm; logic page_write_through; logic [1:0] pins;} csb_row_s;
   logic SYS_CLK, RST_B, PARITY_ERROR_CHECK_ENABLE_B, READ_PARITY_ERR, BURST_READY_IN_B;
   logic MACHINE_CHECK_ENABLE_BIT, MCA_CLEAR, PB_SEL_WR, RUN_STOP_REQ_B, PROBE_ENTER;
   logic PROBE_EXIT, INSN_BOUNDARY, HIGHER_PRI_INT, RSM_EXEC, SYS_MGMT_INTERRUPT_REQ_B;
   logic STOP_CLOCK_REQUEST_B, FLUSH_REQ_B, INIT_REQ, LOCK_START, LOCK_LAST, LOCK_MISALIGNED;
   logic PWT_BIT, SNOOP_REQ, PROBE_READY, SYS_MGMT_ACTIVE_B, STOP_GRANT_CYCLE, EXEC_HALTED;
   logic PARITY_CHECK_OUTPUT_B, LOCK_B, SPLIT_CYCLE, PAGE_WRITE_THROUGH, MACHINE_CHECK_EXC;
   logic CACHE_INVALIDATE, TRISTATE_TEST, RUN_BIST, SNOOP_ACK, stop_on, smi_on;
   logic [1:0] PB_SEL_WDATA, BP_MATCH, PERFMON_EVENT, PERFMON_BREAKPOINT_PINS;
   logic [1:0] PIN_FUNCTION_SELECT, strap;
   csb_cycle_s CUR_CYCLE;
   csb_mca_s MCA_REGS;
   int fails = 0, n_checks = 0, n_parity_check_output = 0, n_sg = 0, n_ci = 0, c;
   csb_row_s rows [4] = '{'{2'h1, 2'h3, 2'h0, 1'h1, 2'h1}, '{2'h2, 2'h3, 2'h0, 1'h0, 2'h2},
      '{2'h3, 2'h2, 2'h1, 1'h1, 2'h2}, '{2'h0, 2'h3, 2'h1, 1'h0, 2'h1}};

   csb_sideband dut
   (
      .SYS_CLK, .RST_B, .PARITY_ERROR_CHECK_ENABLE_B, .READ_PARITY_ERR, .BURST_READY_IN_B,
      .CUR_CYCLE, .MACHINE_CHECK_ENABLE_BIT, .MCA_CLEAR, .PB_SEL_WR, .PB_SEL_WDATA, .BP_MATCH,
      .PERFMON_EVENT, .RUN_STOP_REQ_B, .PROBE_ENTER, .PROBE_EXIT, .INSN_BOUNDARY,
      .HIGHER_PRI_INT, .RSM_EXEC, .SYS_MGMT_INTERRUPT_REQ_B, .STOP_CLOCK_REQUEST_B,
      .FLUSH_REQ_B, .INIT_REQ, .LOCK_START, .LOCK_LAST, .LOCK_MISALIGNED, .PWT_BIT, .SNOOP_REQ,
      .PERFMON_BREAKPOINT_PINS, .PIN_FUNCTION_SELECT, .PROBE_READY, .SYS_MGMT_ACTIVE_B,
      .STOP_GRANT_CYCLE, .EXEC_HALTED, .PARITY_CHECK_OUTPUT_B, .LOCK_B, .SPLIT_CYCLE,
      .PAGE_WRITE_THROUGH, .MACHINE_CHECK_EXC, .MCA_REGS, .CACHE_INVALIDATE, .TRISTATE_TEST,
      .RUN_BIST, .SNOOP_ACK
   );
   csb_chipset chipset
   (
      .STOP_ON(stop_on), .SMI_ON(smi_on), .STRAP(strap), .STOP_CLOCK_REQUEST_B,
      .SYS_MGMT_INTERRUPT_REQ_B, .FLUSH_REQ_B, .INIT_REQ
   );

   initial
   begin
      SYS_CLK = 0;
      forever #12.5 SYS_CLK = ~SYS_CLK;
   end

   // Pulse counts, taken at the edge so the bench reads them race free
   always @(posedge SYS_CLK)
   begin
      n_parity_check_output += (PARITY_CHECK_OUTPUT_B === 1'b0);
      n_sg += (STOP_GRANT_CYCLE === 1'b1);
      n_ci += (CACHE_INVALIDATE === 1'b1);
   end

   // ********
   // Helpers
   // ********
   task automatic ck(string n, logic [39:0] e, logic [39:0] g);
      n_checks++;
      if (g !== e)
      begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask

   task automatic cyc(int n);
      repeat (n) @(negedge SYS_CLK);
   endtask

   task automatic rst(int n);
      RST_B = 0;
      cyc(n);
      RST_B = 1;
   endtask

   task automatic results();
      $display("checks %0d, fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Two back-to-back errors, the second on another address
   task automatic par(logic pen_b, logic mce);
      PARITY_ERROR_CHECK_ENABLE_B = pen_b;
      MACHINE_CHECK_ENABLE_BIT = mce;
      INSN_BOUNDARY = 0;
      cyc(3);
      c = n_parity_check_output;
      CUR_CYCLE = 40'h12345678a5;
      READ_PARITY_ERR = 1;
      BURST_READY_IN_B = 0;
      cyc(1);
      CUR_CYCLE = 40'h0;
      cyc(1);
      READ_PARITY_ERR = 0;
      BURST_READY_IN_B = 1;
      ck("parity_check_output early", 1, PARITY_CHECK_OUTPUT_B);
      cyc(2);
      ck("parity_check_output", 0, PARITY_CHECK_OUTPUT_B);
      cyc(4);
      ck("parity_check_output lows", 2, n_parity_check_output - c);
      ck("mca valid", !pen_b, MCA_REGS.valid);
      if (!pen_b)
         ck("mca cycle", 40'h12345678a5, MCA_REGS.cyc);
      ck("mc exc", !pen_b && mce, MACHINE_CHECK_EXC);
      MCA_CLEAR = 1;
      INSN_BOUNDARY = 1;
      cyc(1);
      MCA_CLEAR = 0;
      cyc(2);
      ck("mca clear", 0, MCA_REGS.valid);
      ck("mc taken", 0, MACHINE_CHECK_EXC);
   endtask

   // ********
   // Tests
   // ********
   initial
   begin
      {READ_PARITY_ERR, MACHINE_CHECK_ENABLE_BIT, MCA_CLEAR, PB_SEL_WR, PB_SEL_WDATA,
         PROBE_ENTER, PROBE_EXIT, INSN_BOUNDARY, HIGHER_PRI_INT, RSM_EXEC, LOCK_START,
         LOCK_LAST, LOCK_MISALIGNED, PWT_BIT, SNOOP_REQ, stop_on, smi_on, strap, RST_B,
         CUR_CYCLE} = '0;
      {PARITY_ERROR_CHECK_ENABLE_B, BURST_READY_IN_B, RUN_STOP_REQ_B} = 3'h7;
      BP_MATCH = 2'h1;
      PERFMON_EVENT = 2'h2;
      rst(2);
      cyc(3);
      ck("invalidate", 1, n_ci);
      ck("pins", 2'h2, PERFMON_BREAKPOINT_PINS);
      ck("smm idle", 1, SYS_MGMT_ACTIVE_B);
      $display("reset test done");
      foreach (rows[i])
      begin
         PB_SEL_WDATA = rows[i].sel;
         PB_SEL_WR = 1;
         BP_MATCH = rows[i].bp;
         PERFMON_EVENT = rows[i].pm;
         PWT_BIT = rows[i].page_write_through;
         cyc(1);
         PB_SEL_WR = 0;
         cyc(2);
         ck("select", rows[i].sel, PIN_FUNCTION_SELECT);
         ck("pins", rows[i].pins, PERFMON_BREAKPOINT_PINS);
         ck("write through", rows[i].page_write_through, PAGE_WRITE_THROUGH);
      end
      $display("row test done");
      par(0, 1);
      par(0, 0);
      par(1, 1);
      $display("parity test done");
      INSN_BOUNDARY = 0;
      smi_on = 1;
      cyc(3);
      smi_on = 0;
      cyc(3);
      ck("smm early", 1, SYS_MGMT_ACTIVE_B);
      INSN_BOUNDARY = 1;
      cyc(2);
      ck("smm", 0, SYS_MGMT_ACTIVE_B);
      cyc(20);
      ck("smm held", 0, SYS_MGMT_ACTIVE_B);
      RSM_EXEC = 1;
      cyc(1);
      RSM_EXEC = 0;
      cyc(2);
      ck("smm exit", 1, SYS_MGMT_ACTIVE_B);
      $display("smm test done");
      c = n_sg;
      HIGHER_PRI_INT = 1;
      stop_on = 1;
      SNOOP_REQ = 1;
      cyc(6);
      ck("preempted", 0, EXEC_HALTED);
      HIGHER_PRI_INT = 0;
      cyc(6);
      ck("halted", 1, EXEC_HALTED);
      ck("snoop", 1, SNOOP_ACK);
      cyc(10);
      ck("grants", 1, n_sg - c);
      ck("held", 1, EXEC_HALTED);
      stop_on = 0;
      cyc(6);
      ck("resumed", 0, EXEC_HALTED);
      $display("stop test done");
      PROBE_ENTER = 1;
      cyc(1);
      PROBE_ENTER = 0;
      cyc(3);
      ck("probe", 1, PROBE_READY);
      PROBE_EXIT = 1;
      cyc(1);
      ck("probe exit", 0, PROBE_READY);
      PROBE_EXIT = 0;
      RUN_STOP_REQ_B = 0;
      cyc(6);
      ck("run stop", 1, PROBE_READY);
      RUN_STOP_REQ_B = 1;
      cyc(6);
      $display("probe test done");
      LOCK_MISALIGNED = 1;
      LOCK_START = 1;
      cyc(1);
      LOCK_START = 0;
      LOCK_LAST = 1;
      cyc(2);
      ck("lock", 0, LOCK_B);
      ck("split", 1, SPLIT_CYCLE);
      BURST_READY_IN_B = 0;
      cyc(1);
      {BURST_READY_IN_B, LOCK_LAST, LOCK_MISALIGNED} = 3'h4;
      cyc(2);
      ck("unlock", 1, LOCK_B);
      $display("lock test done");
      for (int i = 1; i < 3; i++)
      begin
         strap = i[1:0];
         cyc(3);
         rst(4);
         cyc(3);
         ck("three-state", i == 1, TRISTATE_TEST);
         ck("self test", i == 2, RUN_BIST);
         ck("invalidate", i + 1, n_ci);
      end
      $display("strap test done");
      results();
   end

   initial
   begin
      #(25 * 2000);
      fails++;
      results();
   end
endmodule
